// File: inc/art_pkg.sv
package art_pkg;
   // ************************************************
   // register byte offsets
   // ************************************************
   localparam logic [7:0] ART_OFF_MODE = 8'h00; // mode control
   localparam logic [7:0] ART_OFF_FLAG = 8'h04; // flag status
   localparam logic [7:0] ART_OFF_CFG = 8'h08; // clock/edge config
   localparam logic [7:0] ART_OFF_RELOAD = 8'h0C; // reload/capture
   localparam logic [7:0] ART_OFF_CMP = 8'h10; // compare
   localparam logic [7:0] ART_OFF_LIVE = 8'h14; // live load
   localparam logic [7:0] ART_OFF_PRESC = 8'h18; // prescaler readback
   // ************************************************
   // mode control fields
   // ************************************************
   localparam int ART_MC_LOAD = 7; // load command, write only
   localparam int ART_MC_EN = 6; // count enable
   localparam int ART_MC_PWMOE = 5; // pwm pin enable
   localparam int ART_MC_EIE = 4; // edge irq enable
   localparam int ART_MC_CIE = 3; // match irq enable
   localparam int ART_MC_OIE = 2; // overflow irq enable
   // ************************************************
   // flag and config fields
   // ************************************************
   localparam int ART_FL_EDGE = 2; // edge event flag
   localparam int ART_FL_MATCH = 1; // match flag
   localparam int ART_FL_OVF = 0; // overflow flag
   localparam int ART_CF_DIV = 5; // divider select lsb
   localparam int ART_CF_POL = 3; // edge polarity
   localparam int ART_CF_EDGE = 2; // edge detect enable
   // ************************************************
   // reset values and counts
   // ************************************************
   localparam logic [7:0] ART_RST_BYTE = 8'h00; // reset of control regs
   localparam logic [1:0] ART_DIV3_LAST = 2'h2; // divide by three wrap
   localparam logic [7:0] ART_CNT_MAX = 8'hFF; // overflow point
   // ************************************************
   // enumerations
   // ************************************************
   typedef enum logic [1:0] {ART_AUTO, ART_CAP, ART_CAP_RST, ART_EXT_LOAD} art_mode_e;
   typedef enum logic [1:0] {ART_CLK_INT, ART_CLK_DIV3, ART_CLK_PIN, ART_CLK_RSV} art_clk_e;
endpackage : art_pkg

// File: rtl/art_clk_src.sv
`timescale 1ns/100ps
// ************************************************
// clock source select and prescaler tick
// ************************************************
module art_clk_src
   import art_pkg::*;
#(
   parameter int PRE_W = 7
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // control
   input wire logic [1:0] clk_sel,
   input wire logic [2:0] div_sel,
   input wire logic run,
   input wire logic presc_clr,
   input wire logic pin_rise,
   // result
   output logic tick,
   output logic [PRE_W-1:0] timer_prescaler
);
   logic [1:0] div3; // divide by three phase
   logic [1:0] next_div3;
   logic [PRE_W-1:0] next_presc;
   logic src_tick; // one tick of selected source
   logic [PRE_W:0] wide; // prescaler plus carry
   // source mux and prescaler next state
   always_comb begin
      next_div3 = div3;
      unique case (art_clk_e'(clk_sel))
         ART_CLK_INT: src_tick = 1'b1;
         ART_CLK_DIV3: src_tick = (div3 == ART_DIV3_LAST);
         ART_CLK_PIN: src_tick = pin_rise;
         default: src_tick = 1'b0; // reserved: no clock
      endcase
      if (run) begin
         next_div3 = (div3 == ART_DIV3_LAST) ? 2'h0 : div3 + 2'h1;
      end
      wide = {1'b0, timer_prescaler} + {{PRE_W{1'b0}}, 1'b1};
      // tap n fires when the low n bits are all ones: divide by 2^n [RULE3]
      tick = run && src_tick && (&(timer_prescaler | ~((PRE_W'(1) << div_sel) - PRE_W'(1))));
      next_presc = timer_prescaler;
      if (presc_clr) begin
         next_presc = '0; // any load clears prescaler [RULE7]
      end else if (run && src_tick) begin
         next_presc = wide[PRE_W-1:0]; // frozen when not run [RULE4]
      end
   end
   // registers
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         div3 <= 2'h0;
         timer_prescaler <= '0;
      end else begin
         div3 <= next_div3;
         timer_prescaler <= next_presc;
      end
   end
endmodule : art_clk_src

// File: rtl/art_edge_det.sv
`timescale 1ns/100ps
// ************************************************
// event pin edge detector
// ************************************************
module art_edge_det (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // pin and setup
   input wire logic event_in_pin,
   input wire logic edge_detect_enable,
   input wire logic edge_polarity,
   // results
   output logic pin_rise,
   output logic active_edge
);
   logic last; // previous pin level
   logic next_last;
   // edge compare
   always_comb begin
      next_last = event_in_pin;
      pin_rise = event_in_pin && !last;
      // rising when polarity clear, falling when set [RULE21]
      active_edge = edge_detect_enable &&
         (edge_polarity ? (!event_in_pin && last) : pin_rise);
   end
   // register
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         last <= 1'b0;
      end else begin
         last <= next_last;
      end
   end
endmodule : art_edge_det

// File: rtl/art_timer.sv
`timescale 1ns/100ps
// Behaviour
// RULE1: 8-bit up-counter on prescaled clock
// RULE2: clock from internal, internal/3, or pin
// RULE3: prescaler taps divide by 2^n
// RULE4: enable clear freezes prescaler and counter
// RULE5: reset clears counter
// RULE6: live load write loads counter, read returns it
// RULE7: every counter load clears prescaler
// RULE8: auto-reload overflow reloads, pwm high
// RULE9: compare match drives pwm low, sets flag
// RULE10: overflow sets sticky flag
// RULE11: software writes reload, then load plus enable
// RULE12: capture copies counter, sets edge flag
// RULE13: capture-reset clears counter and prescaler
// RULE14: external edge loads counter from reload
// RULE15: pin clock only in auto-reload mode
// RULE16: do not change clock while counting
// RULE17: compare must exceed reload for pwm
// RULE18: writing 06h clears only overflow flag
// RULE19: interrupts wake from wait and stop; stop wake only with pin clock
// RULE20: mode bits select four operating modes
// RULE21: edge enable and polarity select edge
// RULE22: clock select codes, 11 reserved
// RULE23: write zero clears flag, one keeps
// RULE24: one irq line from enabled flags
module art_timer
   import art_pkg::*;
#(
   parameter int PRE_W = 7
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // pins
   input wire logic event_in_pin,
   output logic pwm_out_pin,
   output logic pwm_out_en,
   // interrupt request and wake
   output logic timer_irq,
   output logic stop_wake_ok
);
   // ************************************************
   // state
   // ************************************************
   logic [7:0] mode_control_reg; // bit 7 never stored
   logic [7:0] flag_status_reg; // low three bits used
   logic [7:0] clock_edge_config_reg; // divider, edge, clock
   logic [7:0] reload_capture_reg; // reload or captured value
   logic [7:0] compare_reg; // pwm compare value
   logic [7:0] timer_counter; // main counter
   logic pwm_level; // pwm output state
   logic wr_pend; // write data phase pending
   logic [7:0] wr_addr; // latched write address
   logic [7:0] next_mode, next_flag, next_cfg, next_reload, next_cmp, next_cnt;
   logic next_pwm, next_wr_pend;
   logic [7:0] next_wr_addr;
   logic [31:0] next_rdata;
   // ************************************************
   // helpers
   // ************************************************
   logic tick, pin_rise, active_edge, presc_clr;
   logic [PRE_W-1:0] timer_prescaler;
   art_mode_e op_mode;
   logic addr_ok;
   logic wr_now;
   logic [7:0] wbyte;
   // address decode zeroes read data on unmapped reads and writes; writes decode through the case
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == ART_OFF_MODE) || (a == ART_OFF_FLAG) || (a == ART_OFF_CFG) ||
         (a == ART_OFF_RELOAD) || (a == ART_OFF_CMP) || (a == ART_OFF_LIVE) ||
         (a == ART_OFF_PRESC);
   endfunction : is_mapped
   assign op_mode = art_mode_e'(mode_control_reg[1:0]); // [RULE20]
   assign addr_ok = hsel && hready && htrans[1];
   assign wr_now = wr_pend;
   assign wbyte = hwdata[7:0];
   assign hreadyout = 1'b1; // zero wait states
   assign hresp = 1'b0; // always okay
   // ************************************************
   // submodules
   // ************************************************
   art_edge_det u_edge (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .event_in_pin(event_in_pin),
      .edge_detect_enable(clock_edge_config_reg[ART_CF_EDGE]),
      .edge_polarity(clock_edge_config_reg[ART_CF_POL]),
      .pin_rise(pin_rise),
      .active_edge(active_edge)
   );
   art_clk_src #(.PRE_W(PRE_W)) u_clk ( // [RULE2] [RULE22]
      .ref_clk(ref_clk),
      .resetn(resetn),
      .clk_sel(clock_edge_config_reg[1:0]),
      .div_sel(clock_edge_config_reg[ART_CF_DIV+2 -: 3]),
      .run(mode_control_reg[ART_MC_EN]), // [RULE4]
      .presc_clr(presc_clr),
      .pin_rise(pin_rise),
      .tick(tick),
      .timer_prescaler(timer_prescaler)
   );
   // ************************************************
   // bus, counter and flag next state
   // ************************************************
   always_comb begin
      next_mode = mode_control_reg;
      next_flag = flag_status_reg;
      // software clear first, so an event in the same cycle still sets [RULE23] [RULE18]
      if (wr_now && wr_addr == ART_OFF_FLAG) begin
         next_flag = {5'h00, flag_status_reg[2:0] & wbyte[2:0]};
      end
      next_cfg = clock_edge_config_reg;
      next_reload = reload_capture_reg;
      next_cmp = compare_reg;
      next_cnt = timer_counter;
      next_pwm = pwm_level;
      next_wr_pend = addr_ok && hwrite;
      next_wr_addr = haddr;
      next_rdata = hrdata;
      presc_clr = 1'b0;
      // counting and modes
      if (tick) begin
         if (timer_counter == ART_CNT_MAX) begin
            next_flag[ART_FL_OVF] = 1'b1; // [RULE10]
            next_pwm = 1'b1; // overflow sets pwm [RULE8]
            if (op_mode == ART_AUTO) begin
               next_cnt = reload_capture_reg; // [RULE8]
               presc_clr = 1'b1; // [RULE7]
            end else begin
               next_cnt = 8'h00;
            end
         end else begin
            next_cnt = timer_counter + 8'h01; // [RULE1]
         end
      end
      if (timer_counter == compare_reg && mode_control_reg[ART_MC_EN]) begin
         next_pwm = 1'b0; // [RULE9]
         next_flag[ART_FL_MATCH] = 1'b1; // [RULE9]
      end
      if (active_edge) begin
         unique case (op_mode)
            ART_CAP, ART_CAP_RST: begin
               next_reload = timer_counter; // [RULE12]
               next_flag[ART_FL_EDGE] = 1'b1; // [RULE12]
               if (op_mode == ART_CAP_RST) begin
                  next_cnt = 8'h00; // [RULE13]
                  presc_clr = 1'b1; // [RULE13]
               end
            end
            ART_EXT_LOAD: begin
               next_cnt = reload_capture_reg; // [RULE14]
               next_flag[ART_FL_EDGE] = 1'b1;
               presc_clr = 1'b1; // [RULE7]
            end
            ART_AUTO: next_flag[ART_FL_EDGE] = 1'b1;
         endcase
      end
      // register writes in data phase
      if (wr_now) begin
         unique case (wr_addr)
            ART_OFF_MODE: begin
               next_mode = {1'b0, wbyte[6:0]};
               if (wbyte[ART_MC_LOAD]) begin
                  next_cnt = reload_capture_reg; // load command [RULE7]
                  presc_clr = 1'b1;
               end
            end
            ART_OFF_FLAG: ; // flag clear applied above, before the events
            ART_OFF_CFG: next_cfg = wbyte;
            ART_OFF_RELOAD: next_reload = wbyte;
            ART_OFF_CMP: next_cmp = wbyte;
            ART_OFF_LIVE: begin
               next_cnt = wbyte; // [RULE6]
               presc_clr = 1'b1; // [RULE7]
            end
            default: ;
         endcase
      end
      // read data registered at address phase
      if (addr_ok && !hwrite) begin
         unique case (haddr)
            ART_OFF_MODE: next_rdata = {24'h0, 1'b0, mode_control_reg[6:0]};
            ART_OFF_FLAG: next_rdata = {24'h0, flag_status_reg};
            ART_OFF_CFG: next_rdata = {24'h0, clock_edge_config_reg};
            ART_OFF_RELOAD: next_rdata = {24'h0, reload_capture_reg};
            ART_OFF_CMP: next_rdata = {24'h0, compare_reg};
            ART_OFF_LIVE: next_rdata = {24'h0, timer_counter}; // [RULE6]
            ART_OFF_PRESC: next_rdata = 32'(timer_prescaler);
            default: next_rdata = 32'h0; // unmapped reads zero
         endcase
      end
      if (!is_mapped(haddr) && addr_ok) begin
         next_rdata = 32'h0;
      end
   end
   // ************************************************
   // registers
   // ************************************************
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         mode_control_reg <= ART_RST_BYTE;
         flag_status_reg <= ART_RST_BYTE;
         clock_edge_config_reg <= ART_RST_BYTE;
         reload_capture_reg <= ART_RST_BYTE;
         compare_reg <= ART_RST_BYTE;
         timer_counter <= ART_RST_BYTE; // [RULE5]
         pwm_level <= 1'b0;
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata <= 32'h0;
      end else begin
         mode_control_reg <= next_mode;
         flag_status_reg <= next_flag;
         clock_edge_config_reg <= next_cfg;
         reload_capture_reg <= next_reload;
         compare_reg <= next_cmp;
         timer_counter <= next_cnt;
         pwm_level <= next_pwm;
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         hrdata <= next_rdata;
      end
   end
   // ************************************************
   // outputs
   // ************************************************
   assign pwm_out_pin = pwm_level & mode_control_reg[ART_MC_PWMOE];
   assign pwm_out_en = mode_control_reg[ART_MC_PWMOE];
   // combined request, usable as wait wake [RULE24] [RULE19]
   assign timer_irq = (flag_status_reg[ART_FL_OVF] & mode_control_reg[ART_MC_OIE]) |
      (flag_status_reg[ART_FL_MATCH] & mode_control_reg[ART_MC_CIE]) |
      (flag_status_reg[ART_FL_EDGE] & mode_control_reg[ART_MC_EIE]);
   // stop wake only with pin clock [RULE19]
   assign stop_wake_ok = (art_clk_e'(clock_edge_config_reg[1:0]) == ART_CLK_PIN);
endmodule : art_timer

// File: tb/art_timer_monitor.sv
`timescale 1ns/100ps
// *****
// bus and pin checker
// *****
module art_timer_monitor
   import art_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // bus
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // pins and status
   input wire logic pwm_out_pin,
   input wire logic pwm_out_en,
   input wire logic timer_irq,
   input wire logic stop_wake_ok
);
   logic dp_vld; // data phase pending
   logic dp_wr; // data phase is a write
   logic [7:0] dp_addr; // data phase address
   logic [7:0] wd_q; // written byte, one cycle late
   wire wr_mode = dp_vld && dp_wr && dp_addr == ART_OFF_MODE;
   wire wr_cfg = dp_vld && dp_wr && dp_addr == ART_OFF_CFG;
   wire rd_any = dp_vld && !dp_wr;
   // track the address phase into the data phase
   always_ff @(posedge ref_clk) begin
      dp_vld <= resetn && hsel && hready && htrans[1];
      dp_wr <= hwrite;
      dp_addr <= haddr;
      wd_q <= hwdata[7:0];
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   chk_reset_quiet: assert property ($rose(resetn) |-> !timer_irq && !pwm_out_en)
      else $error("outputs active after reset");
   chk_irq_masked: assert property (wr_mode && hwdata[4:2] == 3'h0 |-> ##[1:2] !timer_irq)
      else $error("irq with all enables off");
   chk_pwm_enable: assert property (wr_mode |=> pwm_out_en == wd_q[ART_MC_PWMOE])
      else $error("pwm enable not following mode");
   chk_pwm_gated: assert property (!pwm_out_en |-> !pwm_out_pin)
      else $error("pwm pin high while disabled");
   chk_wake_pin: assert property (wr_cfg |=> stop_wake_ok == (wd_q[1:0] == 2'h2))
      else $error("wake flag not following clock select");
   chk_load_rd_zero: assert property (rd_any && dp_addr == ART_OFF_MODE |-> !hrdata[7])
      else $error("load command reads one");
   chk_flag_upper: assert property (rd_any && dp_addr == ART_OFF_FLAG |-> hrdata[31:3] == '0)
      else $error("flag upper bits nonzero");
   chk_unmapped_zero: assert property (rd_any && dp_addr > ART_OFF_PRESC |-> hrdata == '0)
      else $error("unmapped read nonzero");
endmodule : art_timer_monitor
bind art_timer art_timer_monitor u_mon (
   .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .pwm_out_pin(pwm_out_pin), .pwm_out_en(pwm_out_en), .timer_irq(timer_irq),
   .stop_wake_ok(stop_wake_ok));

// File: tb/art_pin_model.sv
`timescale 1ns/100ps
// *****
// event pin source, bursts of edges
// *****
module art_pin_model #(
   parameter int DLY = 40
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // burst request
   input wire logic go,
   input wire logic [3:0] burst,
   // pin
   output logic event_in_pin
);
   int cnt; // phase in cycles
   int left; // edges still to send
   // 4 high, 4 low per edge; pin stands low outside bursts
   always @(posedge ref_clk) begin
      if (!resetn) begin
         left <= 0;
         event_in_pin <= 1'b0;
      end else if (go) begin
         cnt <= 0;
         left <= int'(burst);
      end else if (left > 0) begin
         cnt <= (cnt == DLY + 7) ? DLY : cnt + 1;
         event_in_pin <= cnt >= DLY && cnt < DLY + 4;
         if (cnt == DLY + 7) left <= left - 1;
      end
   end
endmodule : art_pin_model

// File: tb/test_art_timer.sv
`timescale 1ns/100ps
// *****
// timer testbench
// *****
module test_art_timer import art_pkg::*;;
   logic ref_clk = 1'b0; // 200 MHz
   logic resetn = 1'b0; // sync reset
   logic hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2; // word transfers
   logic [31:0] hwdata = 32'h0, d, cap;
   logic [3:0] burst = 4'h1; // edges per pin burst
   logic hreadyout, hresp, pwm_out_pin, pwm_out_en, timer_irq, stop_wake_ok, event_in_pin;
   int error_cnt = 0, comparisons = 0, seed = 32'hae31, hi, n;
   logic [31:0] hrdata_w; // read data
   art_timer dut (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata_w), .hreadyout(hreadyout), .hresp(hresp), .event_in_pin(event_in_pin),
      .pwm_out_pin(pwm_out_pin), .pwm_out_en(pwm_out_en), .timer_irq(timer_irq),
      .stop_wake_ok(stop_wake_ok));
   art_pin_model u_pin (.ref_clk(ref_clk), .resetn(resetn), .go(go), .burst(burst),
      .event_in_pin(event_in_pin));
   // *****
   // helpers
   // *****
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // one single transfer, address then data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v,
      output logic [31:0] r);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      htrans <= 2'h0;
      hwdata <= v;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      r = hrdata_w;
      hsel <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] x;
      bus(1'b1, a, v, x);
   endtask : wr
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, d);
      check(nm, d, e);
   endtask : rdc
   // count within two of the figure
   function automatic logic near(input logic [31:0] s, input int e);
      return (^s !== 1'bx) && int'(s) >= e - 2 && int'(s) <= e + 2;
   endfunction : near
   // ticks seen over the 67 enabled cycles of the rate test
   function automatic int exp_cnt(input int sel, input int div);
      return (67 / (2 * sel + 1)) >> div;
   endfunction : exp_cnt
   task automatic print_verdict();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   // *****
   // clock, watchdog, tests
   // *****
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (30000) @(posedge ref_clk);
      error_cnt++;
      print_verdict();
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      rdc("mode", ART_OFF_MODE, 0);
      rdc("flags", ART_OFF_FLAG, 0);
      rdc("counter", ART_OFF_LIVE, 0);
      check("okay", hresp, 0);
      wr(8'h1C, 32'hFF);
      rdc("unmapped", 8'h1C, 0);
      // live load while stopped, then stays frozen
      for (int i = 0; i < 4; i++) begin
         n = $random(seed);
         wr(ART_OFF_LIVE, n[7:0]);
         rdc("live load", ART_OFF_LIVE, n[7:0]);
         repeat (20) @(posedge ref_clk);
         rdc("frozen", ART_OFF_LIVE, n[7:0]);
      end
      // rate for internal and internal/3 sources at a random divider, setup only while stopped
      for (int i = 0; i < 6; i++) begin
         n = $random(seed) & 7;
         wr(ART_OFF_CFG, (n << ART_CF_DIV) | (i & 1));
         wr(ART_OFF_LIVE, 0);
         wr(ART_OFF_MODE, 32'h40);
         repeat (64) @(posedge ref_clk);
         wr(ART_OFF_MODE, 0);
         bus(1'b0, ART_OFF_LIVE, 0, d);
         check("rate", near(d, exp_cnt(i & 1, n)), 1);
      end
      // auto-reload pwm, reload c0, compare e0
      wr(ART_OFF_CFG, 0);
      wr(ART_OFF_RELOAD, 32'hC0);
      wr(ART_OFF_CMP, 32'hE0);
      wr(ART_OFF_MODE, 32'hEC);
      for (int i = 0; i < 400 && pwm_out_pin !== 1'b1; i++) @(posedge ref_clk);
      hi = 0;
      while (pwm_out_pin === 1'b1 && hi < 400) begin
         @(posedge ref_clk);
         hi++;
      end
      check("pwm high", near(hi, 32), 1);
      check("irq", timer_irq, 1);
      // each enable alone: ovf, match, edge
      for (int i = 0; i < 3; i++) begin
         wr(ART_OFF_MODE, 32'h04 << i);
         repeat (2) @(posedge ref_clk);
         check("irq mask", timer_irq, i < 2);
      end
      wr(ART_OFF_MODE, 32'h90);
      rdc("load bit", ART_OFF_MODE, 32'h10);
      rdc("flags set", ART_OFF_FLAG, 3);
      wr(ART_OFF_FLAG, 6);
      rdc("ovf clear", ART_OFF_FLAG, 2);
      wr(ART_OFF_FLAG, 7);
      rdc("write one", ART_OFF_FLAG, 2);
      wr(ART_OFF_FLAG, 0);
      rdc("all clear", ART_OFF_FLAG, 0);
      // capture, capture with reset, load on falling edge
      for (int m = 1; m < 4; m++) begin
         wr(ART_OFF_CFG, m == 3 ? 32'h0C : 32'h04);
         wr(ART_OFF_RELOAD, 32'h55);
         wr(ART_OFF_LIVE, 0);
         wr(ART_OFF_MODE, 32'h50 | m);
         burst <= 4'h1;
         go <= 1'b1;
         @(posedge ref_clk);
         go <= 1'b0;
         repeat (50) @(posedge ref_clk);
         wr(ART_OFF_MODE, 32'h10 | m);
         check("edge irq", timer_irq, 1);
         bus(1'b0, ART_OFF_RELOAD, 0, cap);
         bus(1'b0, ART_OFF_LIVE, 0, d);
         if (m == 1) check("capture", d > cap && cap < 32'h55, 1);
         if (m == 2) check("capture reset", d < 20 && cap > 32, 1);
         if (m == 3) check("edge load", cap == 32'h55 && d > 32'h55 && d < 32'h6A, 1);
         rdc("edge flag", ART_OFF_FLAG, 4);
         wr(ART_OFF_FLAG, 0);
      end
      // ten edges of pin clock in auto-reload mode
      wr(ART_OFF_CFG, 32'h02);
      wr(ART_OFF_LIVE, 0);
      wr(ART_OFF_MODE, 32'h40);
      check("wake", stop_wake_ok, 1);
      burst <= 4'hA;
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      repeat (140) @(posedge ref_clk);
      wr(ART_OFF_MODE, 0);
      rdc("pin clock", ART_OFF_LIVE, 10);
      // reset after the pin clock test, with the counter stopped
      resetn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      rdc("reset counter", ART_OFF_LIVE, 0);
      print_verdict();
   end
endmodule : test_art_timer
